// >>> hdl/hfa_dev_agent.sv
// Purpose: Device end of the processor bus: reset, straps, priority cycles.
// Assumes: Inputs are synchronous to clk; the user owns data bus turns.
// Notes:   A single 25 MHz clock stands in for the strap-selected core clock.
`timescale 1ns/1ns
`default_nettype none

module hfa_dev_agent #(
  parameter int RST_EXT = hfa_pkg::RST_EXT_CYC,
  parameter int HOLD    = hfa_pkg::STRAP_HOLD_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  hfa_fsb_if.dev                         bus,
  input  wire logic                      hub_reset_in_n,
  input  wire logic                      power_good_in,
  input  wire logic [1:0]                frequency_select_strap,
  input  wire logic                      ini_req,
  input  wire logic                      throttle,
  input  wire logic                      defer_en,
  input  wire logic                      tx_valid,
  input  wire logic                      tx_last,
  input  wire logic [hfa_pkg::DATA_W-1:0] tx_data,
  output logic                           ini_done,
  output logic                           cpu_in_reset,
  output hfa_pkg::hfa_rate_t             core_rate,
  output logic                           rx_valid,
  output logic [hfa_pkg::DATA_W-1:0]     rx_data
);
  import hfa_pkg::*;

  // Refused at elaboration so that a bad value never reaches the counters.
  if (RST_EXT < STRAP_SETUP_CYC || RST_EXT >= (1 << 20)) begin : g_ext_chk
    $error("RST_EXT out of range");
  end
  if (HOLD < STRAP_HOLD_MIN || HOLD > STRAP_HOLD_MAX) begin : g_hold_chk
    $error("HOLD out of range");
  end
  if (SNOOP_DLY < 2) begin : g_snoop_chk
    $error("SNOOP_DLY too small");
  end

  typedef enum logic [1:0] {D_IDLE, D_ARB, D_REQ1, D_REQ2} hfa_dstate_t;

  hfa_dstate_t               state_ff;
  hfa_dstate_t               nxt_state;
  logic [19:0]               ext_cnt_ff;
  logic [4:0]                hold_cnt_ff;
  logic                      preset_ff;
  logic                      strap_ff;
  logic                      pg_ff;
  logic [1:0]                fsel_ff;
  logic [SNOOP_DLY-1:0]      snp_ff;
  logic                      defer_ff;
  logic                      block_ff;
  logic                      done_ff;
  logic                      tx_oe_ff;
  logic                      hold_ff;
  logic [DATA_W-1:0]         data_o_ff;
  logic [LANES-1:0]          flag_o_ff;
  logic                      rx_valid_ff;
  logic [DATA_W-1:0]         rx_data_ff;

  localparam logic [19:0] EXT_LAST  = 20'(RST_EXT - 1);
  localparam logic [4:0]  HOLD_LAST = 5'(HOLD - 1);

  wire               strobe_seen = ~bus.request_phase_strobe;
  wire               blocked     = ~bus.next_request_block;
  wire               locked      = ~bus.host_atomic_lock;
  wire               pg_rise     = power_good_in & ~pg_ff;
  wire               ext_done    = (ext_cnt_ff == EXT_LAST);
  wire               hold_done   = (hold_cnt_ff == HOLD_LAST);
  wire               snoop_now   = snp_ff[SNOOP_DLY-2];
  wire               rx_beat     = ~bus.data_valid_cycle & ~tx_oe_ff;
  wire [LANES+DATA_W-1:0] enc    = dbi_encode(tx_data);

  // A start waits for a quiet cycle after any processor strobe, so the two
  // request phases never overlap.
  wire arb_go = ~strobe_seen & ~snp_ff[0] & ~blocked & ~locked;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      D_IDLE: begin
        if (ini_req & ~preset_ff) nxt_state = D_ARB;
      end
      D_ARB: begin
        if (arb_go) nxt_state = D_REQ1;
      end
      D_REQ1: begin
        nxt_state = D_REQ2;
      end
      D_REQ2: begin
        nxt_state = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= D_IDLE;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff  <= (state_ff == D_REQ2);
    end
  end

  assign bus.dev_strobe_oe = (state_ff == D_REQ1);
  assign bus.prio_oe       = (state_ff != D_IDLE);

  // Processor reset follows the hub reset, then stretches for the extension.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preset_ff  <= 1'b1;
      ext_cnt_ff <= '0;
    end else if (!hub_reset_in_n) begin
      preset_ff  <= 1'b1;
      ext_cnt_ff <= '0;
    end else if (preset_ff) begin
      ext_cnt_ff <= ext_cnt_ff + 20'h1;
      if (ext_done) preset_ff <= 1'b0;
    end
  end

  // The strap leads the reset release by the whole reset time, far above
  // the set-up need, and trails it by HOLD cycles.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_ff    <= 1'b1;
      hold_cnt_ff <= '0;
    end else if (preset_ff) begin
      strap_ff    <= 1'b1;
      hold_cnt_ff <= '0;
    end else begin
      strap_ff <= ~hold_done;
      if (!hold_done) hold_cnt_ff <= hold_cnt_ff + 5'h1;
    end
  end

  assign bus.preset_oe = preset_ff;
  assign bus.strap_oe  = strap_ff;

  // The strap is only looked at on the power-good edge; later changes on
  // the pins have no effect until power cycles.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_ff   <= 1'b0;
      fsel_ff <= FSEL_RST;
    end else begin
      pg_ff <= power_good_in;
      if (pg_rise) fsel_ff <= frequency_select_strap;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snp_ff   <= '0;
      defer_ff <= 1'b0;
      block_ff <= 1'b0;
    end else begin
      snp_ff   <= {snp_ff[SNOOP_DLY-2:0], strobe_seen};
      defer_ff <= snoop_now & defer_en;
      block_ff <= throttle;
    end
  end

  assign bus.defer_oe     = defer_ff;
  assign bus.dev_block_oe = block_ff;

  // Data is sent in the cycle after tx_valid; the hold line covers every
  // beat but the last.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_oe_ff  <= 1'b0;
      hold_ff   <= 1'b0;
      data_o_ff <= '1;
      flag_o_ff <= '1;
    end else begin
      tx_oe_ff  <= tx_valid;
      hold_ff   <= tx_valid & ~tx_last;
      data_o_ff <= enc[DATA_W-1:0];
      flag_o_ff <= enc[LANES+DATA_W-1:DATA_W];
    end
  end

  assign bus.dev_data_valid_cycle_oe = tx_oe_ff;
  assign bus.dev_data_oe = tx_oe_ff;
  assign bus.dev_hold_oe = hold_ff;
  assign bus.dev_data_o  = data_o_ff;
  assign bus.dev_flag_o  = flag_o_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid_ff <= 1'b0;
      rx_data_ff  <= '0;
    end else begin
      rx_valid_ff <= rx_beat;
      if (rx_beat)
        rx_data_ff <= dbi_decode(bus.host_data_bus,
                                 bus.lane_inversion_flags);
    end
  end

  hfa_rate_t rate_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_ff <= RATE_100;
    end else begin
      rate_ff <= decode_fsel(fsel_ff);
    end
  end

  assign ini_done     = done_ff;
  assign cpu_in_reset = preset_ff;
  assign core_rate    = rate_ff;
  assign rx_valid     = rx_valid_ff;
  assign rx_data      = rx_data_ff;

endmodule

`default_nettype wire

// >>> hdl/hfa_pkg.sv
// Purpose: Shared constants, types and helpers of the processor bus agents.
// Assumes: One 25 MHz clock; pins are active low, pulled up when undriven.
// Notes:   Bus data is carried inverted; lanes may be flipped again.

package hfa_pkg;

  localparam int DATA_W  = 64;
  localparam int LANE_W  = 16;
  localparam int LANES   = 4;
  localparam int LOW_MAX = 8;

  localparam int CLK_MHZ      = 25;
  localparam int T_RST_EXT_US = 1000;
  localparam int RST_EXT_CYC  = T_RST_EXT_US * CLK_MHZ;

  localparam int STRAP_SETUP_CYC = 4;
  localparam int STRAP_HOLD_MIN  = 2;
  localparam int STRAP_HOLD_MAX  = 20;
  localparam int STRAP_HOLD_CYC  = 10;

  // Cycles from a request strobe to the snoop phase of that request.
  localparam int SNOOP_DLY = 3;

  localparam logic [1:0] FSEL_100 = 2'h0;
  localparam logic [1:0] FSEL_133 = 2'h1;
  localparam logic [1:0] FSEL_200 = 2'h2;
  localparam logic [1:0] FSEL_RST = 2'h0;

  typedef enum logic [1:0] {RATE_100, RATE_133, RATE_200, RATE_RSVD} hfa_rate_t;

  function automatic hfa_rate_t decode_fsel(input logic [1:0] s);
    hfa_rate_t r;
    r = RATE_RSVD;
    if (s == FSEL_100) r = RATE_100;
    if (s == FSEL_133) r = RATE_133;
    if (s == FSEL_200) r = RATE_200;
    return r;
  endfunction

  // Returns {lane flag levels, pin levels}; a low flag marks a lane sent
  // uninverted on the pins, which keeps its low bit count at or under 8.
  function automatic logic [LANES+DATA_W-1:0] dbi_encode(
    input logic [DATA_W-1:0] v);
    logic [LANES-1:0]  f;
    logic [DATA_W-1:0] e;
    int                ones;
    f = '1;
    e = ~v;
    for (int i = 0; i < LANES; i++) begin
      ones = 0;
      for (int b = 0; b < LANE_W; b++) begin
        ones = ones + int'(v[i*LANE_W+b]);
      end
      if (ones > LOW_MAX) begin
        f[i] = 1'b0;
        e[i*LANE_W +: LANE_W] = v[i*LANE_W +: LANE_W];
      end
    end
    return {f, e};
  endfunction

  function automatic logic [DATA_W-1:0] dbi_decode(
    input logic [DATA_W-1:0] e,
    input logic [LANES-1:0]  f);
    logic [DATA_W-1:0] v;
    v = '0;
    for (int i = 0; i < LANES; i++) begin
      v[i*LANE_W +: LANE_W] = f[i] ? ~e[i*LANE_W +: LANE_W]
                                   : e[i*LANE_W +: LANE_W];
    end
    return v;
  endfunction

endpackage

// >>> hdl/hfa_fsb_if.sv
// Purpose: Front-side bus wires between the device and the processor.
// Assumes: Every control pin is active low and pulled up when undriven.
// Notes:   Each end gives enables; the level is resolved here.
`timescale 1ns/1ns
`default_nettype none

interface hfa_fsb_if;
  import hfa_pkg::*;

  logic              dev_strobe_oe,  cpu_strobe_oe;
  logic              dev_block_oe,   cpu_block_oe;
  logic              dev_hold_oe,    cpu_hold_oe;
  logic              dev_data_valid_cycle_oe,    cpu_data_valid_cycle_oe;
  logic              dev_data_oe,    cpu_data_oe;
  logic [DATA_W-1:0] dev_data_o,     cpu_data_o;
  logic [LANES-1:0]  dev_flag_o,     cpu_flag_o;
  logic              prio_oe;
  logic              strap_oe;
  logic              preset_oe;
  logic              defer_oe;
  logic              lock_oe;

  wire               request_phase_strobe   = ~(dev_strobe_oe | cpu_strobe_oe);
  wire               next_request_block     = ~(dev_block_oe | cpu_block_oe);
  wire               data_bus_hold          = ~(dev_hold_oe | cpu_hold_oe);
  wire               data_valid_cycle       = ~(dev_data_valid_cycle_oe | cpu_data_valid_cycle_oe);
  wire               priority_agent_request = ~prio_oe;
  wire               bus_request_zero_strap = ~strap_oe;
  wire               processor_reset_out    = ~preset_oe;
  wire               snoop_defer            = ~defer_oe;
  wire               host_atomic_lock       = ~lock_oe;
  wire [DATA_W-1:0]  host_data_bus =
    ~(({DATA_W{dev_data_oe}} & ~dev_data_o) |
      ({DATA_W{cpu_data_oe}} & ~cpu_data_o));
  wire [LANES-1:0]   lane_inversion_flags =
    ~(({LANES{dev_data_oe}} & ~dev_flag_o) |
      ({LANES{cpu_data_oe}} & ~cpu_flag_o));

  modport dev (
    output dev_strobe_oe, dev_block_oe, dev_hold_oe, dev_data_valid_cycle_oe,
    output dev_data_oe, dev_data_o, dev_flag_o,
    output prio_oe, strap_oe, preset_oe, defer_oe,
    input  request_phase_strobe, next_request_block, data_bus_hold,
    input  data_valid_cycle, host_atomic_lock, host_data_bus,
    input  lane_inversion_flags
  );

  modport cpu (
    output cpu_strobe_oe, cpu_block_oe, cpu_hold_oe, cpu_data_valid_cycle_oe,
    output cpu_data_oe, cpu_data_o, cpu_flag_o, lock_oe,
    input  request_phase_strobe, next_request_block, data_bus_hold,
    input  data_valid_cycle, priority_agent_request,
    input  bus_request_zero_strap, processor_reset_out, snoop_defer,
    input  host_data_bus, lane_inversion_flags
  );

endinterface

`default_nettype wire

// >>> hdl/hfa_cpu_agent.sv
// Purpose: Processor end of the bus: symmetric requests, lock, data.
// Assumes: Inputs are synchronous to clk.
// Notes:   The bus-request-zero strap is sampled as processor reset lifts.
`timescale 1ns/1ns
`default_nettype none

module hfa_cpu_agent (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  hfa_fsb_if.cpu                          bus,
  input  wire logic                       cpu_req,
  input  wire logic                       cpu_lock,
  input  wire logic                       throttle,
  input  wire logic                       tx_valid,
  input  wire logic                       tx_last,
  input  wire logic [hfa_pkg::DATA_W-1:0] tx_data,
  output logic                            req_done,
  output logic                            in_reset,
  output logic                            strap_low,
  output logic                            defer_seen,
  output logic                            rx_valid,
  output logic [hfa_pkg::DATA_W-1:0]      rx_data
);
  import hfa_pkg::*;

  typedef enum logic [1:0] {P_IDLE, P_REQ1, P_REQ2} hfa_pstate_t;

  hfa_pstate_t        state_ff;
  hfa_pstate_t        nxt_state;
  logic               done_ff;
  logic               rst_seen_ff;
  logic               strap_ff;
  logic               defer_ff;
  logic               block_ff;
  logic               lock_ff;
  logic               tx_oe_ff;
  logic               hold_ff;
  logic [DATA_W-1:0]  data_o_ff;
  logic [LANES-1:0]   flag_o_ff;
  logic               rx_valid_ff;
  logic [DATA_W-1:0]  rx_data_ff;

  wire               preset   = ~bus.processor_reset_out;
  wire               prio     = ~bus.priority_agent_request;
  wire               blocked  = ~bus.next_request_block;
  wire               strobing = ~bus.request_phase_strobe;
  wire               rx_beat  = ~bus.data_valid_cycle & ~tx_oe_ff;
  wire [LANES+DATA_W-1:0] enc = dbi_encode(tx_data);

  // Under priority only a locked sequence may go on.
  wire may_start = cpu_req & ~preset & ~blocked & ~strobing &
                   (~prio | lock_ff);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      P_IDLE: begin
        if (may_start) nxt_state = P_REQ1;
      end
      P_REQ1: begin
        nxt_state = P_REQ2;
      end
      P_REQ2: begin
        nxt_state = P_IDLE;
      end
      default: begin
        nxt_state = P_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= P_IDLE;
      done_ff     <= 1'b0;
      rst_seen_ff <= 1'b1;
      strap_ff    <= 1'b0;
      defer_ff    <= 1'b0;
      block_ff    <= 1'b0;
      lock_ff     <= 1'b0;
    end else begin
      state_ff    <= preset ? P_IDLE : nxt_state;
      done_ff     <= (state_ff == P_REQ2);
      rst_seen_ff <= preset;
      if (rst_seen_ff & ~preset)
        strap_ff <= ~bus.bus_request_zero_strap;
      defer_ff    <= ~bus.snoop_defer;
      block_ff    <= throttle;
      lock_ff     <= cpu_lock & ~preset;
    end
  end

  assign bus.cpu_strobe_oe = (state_ff == P_REQ1);
  assign bus.cpu_block_oe  = block_ff;
  assign bus.lock_oe       = lock_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_oe_ff    <= 1'b0;
      hold_ff     <= 1'b0;
      data_o_ff   <= '1;
      flag_o_ff   <= '1;
      rx_valid_ff <= 1'b0;
      rx_data_ff  <= '0;
    end else begin
      tx_oe_ff    <= tx_valid;
      hold_ff     <= tx_valid & ~tx_last;
      data_o_ff   <= enc[DATA_W-1:0];
      flag_o_ff   <= enc[LANES+DATA_W-1:DATA_W];
      rx_valid_ff <= rx_beat;
      if (rx_beat)
        rx_data_ff <= dbi_decode(bus.host_data_bus, bus.lane_inversion_flags);
    end
  end

  assign bus.cpu_data_valid_cycle_oe = tx_oe_ff;
  assign bus.cpu_data_oe = tx_oe_ff;
  assign bus.cpu_hold_oe = hold_ff;
  assign bus.cpu_data_o  = data_o_ff;
  assign bus.cpu_flag_o  = flag_o_ff;

  assign req_done   = done_ff;
  assign in_reset   = rst_seen_ff;
  assign strap_low  = strap_ff;
  assign defer_seen = defer_ff;
  assign rx_valid   = rx_valid_ff;
  assign rx_data    = rx_data_ff;

endmodule

`default_nettype wire

// >>> tb/hfa_fsb_assertions.sv
// Purpose: Concurrent checks on the wires between the two bus ends.
// Assumes: One clock domain; every pin is active low.
// Notes:   Instantiated beside the bus interface, fed by its signals.
`timescale 1ns/1ns
`default_nettype none

module hfa_fsb_assertions
  import hfa_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              request_phase_strobe,
  input wire logic              next_request_block,
  input wire logic              priority_agent_request,
  input wire logic              host_atomic_lock,
  input wire logic              bus_request_zero_strap,
  input wire logic              processor_reset_out,
  input wire logic              data_bus_hold,
  input wire logic              data_valid_cycle,
  input wire logic              dev_strobe_oe,
  input wire logic              cpu_strobe_oe,
  input wire logic              prio_oe,
  input wire logic              defer_oe,
  input wire logic              dev_data_oe,
  input wire logic              cpu_data_oe,
  input wire logic [DATA_W-1:0] host_data_bus
);
  logic lanes_ok;

  // A lane flagged wrongly can still carry the right value, so count lows.
  always_comb begin
    lanes_ok = 1'b1;
    for (int i = 0; i < LANES; i++) begin
      if ($countones(~host_data_bus[i*LANE_W +: LANE_W]) > LOW_MAX) begin
        lanes_ok = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence strap_held;
    (!bus_request_zero_strap)[*3];
  endsequence

  sequence strap_freed;
    ##[0:17] bus_request_zero_strap;
  endsequence

  strobe_one_cycle_a: assert property ($fell(request_phase_strobe) |=> request_phase_strobe)
    else $error("request strobe held past one cycle");
  block_stall_a: assert property (!next_request_block |=> request_phase_strobe)
    else $error("request started while blocked");
  own_prio_a: assert property (dev_strobe_oe |-> prio_oe)
    else $error("device strobe without priority request");
  prio_yield_a: assert property (!priority_agent_request && host_atomic_lock |=> !cpu_strobe_oe)
    else $error("processor request under priority");
  strap_reset_a: assert property (!processor_reset_out |-> !bus_request_zero_strap)
    else $error("strap released during processor reset");
  strap_setup_a: assert property ($rose(processor_reset_out) |-> $past(bus_request_zero_strap, 4) == 1'b0)
    else $error("strap setup too short");
  strap_hold_a: assert property ($rose(processor_reset_out) |-> strap_held ##1 strap_freed)
    else $error("strap hold outside window");
  defer_slot_a: assert property (defer_oe |-> $past(request_phase_strobe, 3) == 1'b0)
    else $error("deferral outside snoop phase");
  ready_drive_a: assert property ((dev_data_oe || cpu_data_oe) == !data_valid_cycle)
    else $error("data ready not matching data drive");
  lane_low_a: assert property (!data_valid_cycle |-> lanes_ok)
    else $error("lane with more than eight lows");
  busy_hold_a: assert property (!data_bus_hold |-> !data_valid_cycle ##1 !data_valid_cycle)
    else $error("data busy without following beat");
endmodule

`default_nettype wire

// >>> tb/host_fsb_control_agent_bench.sv
// Purpose: Self-checking bench joining both ends of the processor bus.
// Assumes: 25 MHz clock; inputs change on the falling edge.
// Notes:   A short reset extension keeps the run brief.
`timescale 1ns/1ns
`default_nettype none

module host_fsb_control_agent_bench;
  import hfa_pkg::*;

  localparam int        EXT = 8;
  localparam hfa_rate_t RATES [4] = '{RATE_100, RATE_133, RATE_200, RATE_RSVD};

  logic        clk, rst_n, hub_rst_n, pg, ini_req, cpu_req, cpu_lock;
  logic        d_thr, c_thr, defer_en, dir, vld, last;
  logic [1:0]  fsel, fin;
  logic [63:0] dat, d_rx, c_rx;
  logic        ini_done, cpu_in_reset, d_rx_v, req_done, in_reset;
  logic        strap_low, defer_seen, c_rx_v;
  hfa_rate_t   core_rate;
  int          bad_count, n_tests, cyc, seed, n, stb, dfr;
  logic [63:0] q_d[$], q_c[$], q_w[$];

  hfa_fsb_if fsb ();

  hfa_dev_agent #(.RST_EXT(EXT)) i_hfa_dev_agent (
    .clk(clk), .rst_n(rst_n), .bus(fsb), .hub_reset_in_n(hub_rst_n),
    .power_good_in(pg), .frequency_select_strap(fsel), .ini_req(ini_req),
    .throttle(d_thr), .defer_en(defer_en), .tx_valid(vld & ~dir),
    .tx_last(last), .tx_data(dat), .ini_done(ini_done),
    .cpu_in_reset(cpu_in_reset), .core_rate(core_rate),
    .rx_valid(d_rx_v), .rx_data(d_rx));

  hfa_cpu_agent i_hfa_cpu_agent (
    .clk(clk), .rst_n(rst_n), .bus(fsb), .cpu_req(cpu_req),
    .cpu_lock(cpu_lock), .throttle(c_thr), .tx_valid(vld & dir),
    .tx_last(last), .tx_data(dat), .req_done(req_done),
    .in_reset(in_reset), .strap_low(strap_low), .defer_seen(defer_seen),
    .rx_valid(c_rx_v), .rx_data(c_rx));

  hfa_fsb_assertions i_chk (
    .clk(clk), .rst_n(rst_n),
    .request_phase_strobe(fsb.request_phase_strobe),
    .next_request_block(fsb.next_request_block),
    .priority_agent_request(fsb.priority_agent_request),
    .host_atomic_lock(fsb.host_atomic_lock),
    .bus_request_zero_strap(fsb.bus_request_zero_strap),
    .processor_reset_out(fsb.processor_reset_out),
    .data_bus_hold(fsb.data_bus_hold),
    .data_valid_cycle(fsb.data_valid_cycle),
    .dev_strobe_oe(fsb.dev_strobe_oe), .cpu_strobe_oe(fsb.cpu_strobe_oe),
    .prio_oe(fsb.prio_oe), .defer_oe(fsb.defer_oe),
    .dev_data_oe(fsb.dev_data_oe), .cpu_data_oe(fsb.cpu_data_oe),
    .host_data_bus(fsb.host_data_bus));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A low flag marks a lane carried uninverted; others arrive inverted.
  function automatic logic [63:0] unflip(input logic [63:0] p,
                                         input logic [3:0]  f);
    for (int i = 0; i < 4; i++) begin
      p[i*16 +: 16] = f[i] ? ~p[i*16 +: 16] : p[i*16 +: 16];
    end
    return p;
  endfunction

  // Sampled mid-cycle, away from the edge that launches the design's flops.
  always @(negedge clk) begin
    if (rst_n && fsb.data_valid_cycle === 1'b0) begin
      chk(unflip(fsb.host_data_bus, fsb.lane_inversion_flags) === q_w.pop_front(), "wire data");
    end
    if (c_rx_v === 1'b1) chk(c_rx === q_c.pop_front(), "cpu rx");
    if (d_rx_v === 1'b1) chk(d_rx === q_d.pop_front(), "dev rx");
    if (rst_n && fsb.request_phase_strobe === 1'b0) stb++;
    if (defer_seen === 1'b1) dfr++;
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  // Requests are dropped at their done pulse so no second cycle starts.
  task automatic serve(input int lim);
    logic [1:0] want;
    want = {cpu_req, ini_req};
    fin = 2'b00;
    for (int i = 0; i < lim && fin != want; i++) begin
      @(negedge clk);
      if (ini_done === 1'b1) begin
        ini_req = 1'b0;
        fin[0] = 1'b1;
      end
      if (req_done === 1'b1) begin
        cpu_req = 1'b0;
        cpu_lock = 1'b0;
        fin[1] = 1'b1;
      end
    end
  endtask

  task automatic send(input int beats);
    for (int i = 0; i < beats; i++) begin
      @(negedge clk);
      vld = 1'b1;
      last = (i == beats - 1);
      dat = (i == 0) ? 64'h00ff_01ff_fe00_0000 : {$random(seed), $random(seed)};
      q_w.push_back(dat);
      if (dir) q_d.push_back(dat);
      else q_c.push_back(dat);
    end
    @(negedge clk);
    vld = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  initial begin
    seed = 32'ha569_142c;
    {rst_n, hub_rst_n, pg, ini_req, cpu_req, cpu_lock} = 6'h00;
    {d_thr, c_thr, defer_en, dir, vld, last} = 6'h00;
    fsel = 2'h0;
    dat = 64'h0000_0000_0000_0000;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk(cpu_in_reset === 1'b1 && fsb.processor_reset_out === 1'b0, "reset");
    chk(in_reset === 1'b1 && fsb.bus_request_zero_strap === 1'b0, "strap");
    hub_rst_n = 1'b1;
    for (n = 0; fsb.processor_reset_out !== 1'b1 && n < 100; n++) @(negedge clk);
    chk(n >= EXT && n <= EXT + 4, "reset extension");
    for (n = 0; fsb.bus_request_zero_strap !== 1'b1 && n < 100; n++) @(negedge clk);
    chk(n >= 2 && n <= 20 && strap_low === 1'b1, "strap hold");
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      fsel = k[1:0];
      pg = 1'b1;
      repeat (3) @(negedge clk);
      chk(core_rate === RATES[k], "rate decode");
      fsel = ~fsel;
      repeat (2) @(negedge clk);
      chk(core_rate === RATES[k], "rate kept");
      pg = 1'b0;
      @(negedge clk);
    end
    $display("strap test done");
    for (int k = 0; k < 2; k++) begin
      defer_en = k[0];
      n = stb;
      dfr = 0;
      ini_req = 1'b1;
      serve(20);
      repeat (5) @(negedge clk);
      chk(fin === 2'b01 && stb == n + 1, "device cycle");
      chk((dfr > 0) === k[0], "deferral");
    end
    $display("device request test done");
    for (int k = 0; k < 2; k++) begin
      d_thr = !k[0];
      c_thr = k[0];
      repeat (2) @(negedge clk);
      if (k == 0) cpu_req = 1'b1;
      else ini_req = 1'b1;
      serve(10);
      chk(fin === 2'b00, "blocked");
      {d_thr, c_thr} = 2'b00;
      serve(12);
      chk(fin === (k == 0 ? 2'b10 : 2'b01), "unblocked");
    end
    for (int k = 0; k < 2; k++) begin
      cpu_lock = k[0];
      ini_req = 1'b1;
      cpu_req = 1'b1;
      serve(60);
      chk(fin === 2'b11, "both served");
    end
    cpu_lock = 1'b0;
    $display("request test done");
    for (int k = 0; k < 8; k++) begin
      dir = k[0];
      send(1 + ($random(seed) & 3));
    end
    chk(q_c.size() == 0 && q_d.size() == 0 && q_w.size() == 0, "drained");
    $display("data test done");
    final_report();
  end
endmodule

`default_nettype wire
